/* ssfg_asserts.sv */
// Port checker for the strap latch and serial configuration block
`timescale 1ns/10ps
module ssfg_asserts #(
	parameter int unsigned SAMPLE_CYCLES = 50
) (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic SERIAL_CLOCK_PIN,
	input wire logic SERIAL_DATA_PIN_O,
	input wire logic SERIAL_DATA_PIN_OE,
	input wire logic REFERENCE_COPY_STRAP_PIN_O,
	input wire logic REFERENCE_COPY_STRAP_PIN_OE,
	input wire logic CRYSTAL_INPUT,
	input wire logic HALF_RATE_SELECT_STRAP,
	input wire logic STRAP_LATCHED,
	input wire logic [4:0] FREQ_CODE
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	int unsigned cnt_q;
	// Cycles since power-on release, saturating so it never wraps
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) cnt_q <= 0;
		else if (cnt_q < SAMPLE_CYCLES + 4) cnt_q <= cnt_q + 1;
	end
	sequence s_ack_up;
		$rose(SERIAL_DATA_PIN_OE);
	endsequence
	sequence s_ack_hold;
		SERIAL_DATA_PIN_OE [*3];
	endsequence
	chk_sample_float:
		assert property (cnt_q < SAMPLE_CYCLES |-> !REFERENCE_COPY_STRAP_PIN_OE) else $error("strap pin driven early");
	chk_latch_timely:
		assert property (cnt_q == SAMPLE_CYCLES + 3 |-> STRAP_LATCHED) else $error("strap not latched in time");
	chk_drive_after:
		assert property (REFERENCE_COPY_STRAP_PIN_OE |-> STRAP_LATCHED) else $error("drive before latch");
	chk_strap_hold:
		assert property ($past(STRAP_LATCHED) |-> $stable(HALF_RATE_SELECT_STRAP)) else $error("strap bit moved");
	chk_ref_copy:
		assert property (REFERENCE_COPY_STRAP_PIN_OE |-> REFERENCE_COPY_STRAP_PIN_O == $past(CRYSTAL_INPUT, 4))
		else $error("reference copy wrong");
	chk_freq_step:
		assert property (FREQ_CODE != $past(FREQ_CODE) |-> (FREQ_CODE == 5'($past(FREQ_CODE) + 1)
			|| FREQ_CODE == 5'($past(FREQ_CODE) - 1))) else $error("frequency jumped");
	chk_ack_slot:
		assert property (s_ack_up |-> !SERIAL_CLOCK_PIN ##1 s_ack_hold) else $error("acknowledge misplaced");
	chk_no_read:
		assert property (SERIAL_DATA_PIN_O == 1'b0) else $error("data pin driven high");
endmodule : ssfg_asserts
bind ssfg_top ssfg_asserts #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
	.SERIAL_CLOCK_PIN(SERIAL_CLOCK_PIN), .SERIAL_DATA_PIN_O(SERIAL_DATA_PIN_O),
	.SERIAL_DATA_PIN_OE(SERIAL_DATA_PIN_OE), .REFERENCE_COPY_STRAP_PIN_O(REFERENCE_COPY_STRAP_PIN_O),
	.REFERENCE_COPY_STRAP_PIN_OE(REFERENCE_COPY_STRAP_PIN_OE), .CRYSTAL_INPUT(CRYSTAL_INPUT),
	.HALF_RATE_SELECT_STRAP(HALF_RATE_SELECT_STRAP), .STRAP_LATCHED(STRAP_LATCHED), .FREQ_CODE(FREQ_CODE));

/* ssfg_host.sv */
// Two-wire bus master model standing in for the chipset
`timescale 1ns/10ps
module ssfg_host (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	int lo = 10;
	// Bus idles with the clock driven high and data released to the pull-up
	initial begin
		scl = 1;
		sda_low = 0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt
	// Data moves only mid-low so it never fakes a start or stop
	task automatic slot(input logic b, output logic s);
		sda_low <= !b;
		wt(lo);
		scl <= 1;
		wt(20);
		s = sda;
		scl <= 0;
		wt(lo);
	endtask : slot
	task automatic start;
		sda_low <= 1;
		wt(20);
		scl <= 0;
		wt(lo);
	endtask : start
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) slot(b[i], s);
		slot(1'b1, s);
		ack = !s;
	endtask : put_byte
	task automatic stop;
		sda_low <= 1;
		wt(lo);
		scl <= 1;
		wt(20);
		sda_low <= 0;
		wt(20);
	endtask : stop
endmodule : ssfg_host

/* ssfg_pkg.sv */
// Constants, field layouts and types shared by the strap latch and serial configuration block
package ssfg_pkg;

	// Timing
	localparam int unsigned SYS_CLK_MHZ = 250;
	localparam int unsigned STRAP_SAMPLE_US = 2000;
	localparam int unsigned STRAP_SAMPLE_CYCLES = STRAP_SAMPLE_US * SYS_CLK_MHZ;
	localparam logic [15:0] RAMP_DIV_RESET = 16'h0100;

	// Serial sequence
	localparam logic [7:0] SER_SLAVE_ADDR = 8'hD2;
	localparam logic [3:0] SER_SEQ_BYTES = 4'hA;
	localparam logic [3:0] SER_FIRST_CFG_IDX = 4'h6;
	localparam logic [3:0] SER_LAST_CFG_IDX = 4'h9;
	localparam logic [3:0] SER_BITS_PER_BYTE = 4'h8;

	// Control bytes three to six
	typedef struct packed {
		logic [7:0] b3;
		logic [7:0] b4;
		logic [7:0] b5;
		logic [7:0] b6;
	} ssfg_cfg_t;
	localparam ssfg_cfg_t CFG_DEFAULT = '{b3: 8'h00, b4: 8'h45, b5: 8'hEF, b6: 8'h00};

	// Field positions
	localparam int unsigned B3_SEL_MSB = 7;
	localparam int unsigned B3_SEL_LSB = 4;
	localparam int unsigned B3_TABLE_SEL = 3;
	localparam int unsigned B3_MODE_MSB = 1;
	localparam int unsigned B3_MODE_LSB = 0;
	localparam int unsigned B4_ALT_EN = 6;
	localparam int unsigned B4_CPU1_EN = 2;
	localparam int unsigned B4_CPU0_EN = 0;
	localparam int unsigned B5_PCIF_EN = 7;
	localparam int unsigned B5_PCI6_EN = 6;
	localparam int unsigned B5_PCI5_EN = 5;
	localparam int unsigned B5_PCI4_EN = 3;
	localparam int unsigned B5_PCI3_EN = 2;
	localparam int unsigned B5_PCI2_EN = 1;
	localparam int unsigned B5_PCI1_EN = 0;

	// Operating modes
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_TEST = 2'b01,
		MODE_SPREAD = 2'b10,
		MODE_TRISTATE = 2'b11
	} ssfg_mode_t;

	// Clock output indices
	localparam int unsigned NUM_CLK_OUT = 10;
	localparam int unsigned OUT_CPU0 = 0;
	localparam int unsigned OUT_CPU1 = 1;
	localparam int unsigned OUT_ALT = 2;
	localparam int unsigned OUT_PCI1 = 3;
	localparam int unsigned OUT_PCIF = 9;

	// APB map
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_CONFIG = 8'h04;
	localparam logic [7:0] REG_RAMP_DIV = 8'h08;
	localparam logic [7:0] REG_FREQ = 8'h0C;
	localparam int unsigned ST_DONE_BIT = 0;
	localparam int unsigned ST_STRAP_BIT = 1;
	localparam int unsigned ST_BUSY_BIT = 2;
	localparam int unsigned ST_SLEW_BIT = 3;

	// Strap sequencer states, Gray along the path
	typedef enum logic [1:0] {
		STRAP_SAMPLE = 2'b00,
		STRAP_LATCH = 2'b01,
		STRAP_DRIVE = 2'b11
	} ssfg_strap_t;

	// Serial receiver states
	typedef enum logic [1:0] {
		SER_IDLE = 2'b00,
		SER_RX = 2'b01,
		SER_ACK = 2'b11,
		SER_SKIP = 2'b10
	} ssfg_ser_t;

endpackage : ssfg_pkg

/* ssfg_top.sv */
// Strap latch, serial configuration receiver and APB status port of the frequency generator
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module ssfg_top
	import ssfg_pkg::*;
#(
	parameter int unsigned SAMPLE_CYCLES = STRAP_SAMPLE_CYCLES
) (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic SERIAL_CLOCK_PIN,
	input wire logic SERIAL_DATA_PIN_I,
	output logic SERIAL_DATA_PIN_O,
	output logic SERIAL_DATA_PIN_OE,
	input wire logic REFERENCE_COPY_STRAP_PIN_I,
	output logic REFERENCE_COPY_STRAP_PIN_O,
	output logic REFERENCE_COPY_STRAP_PIN_OE,
	input wire logic CRYSTAL_INPUT,
	input wire logic CPU_SPEED_SELECT_PIN,
	output logic HALF_RATE_SELECT_STRAP,
	output logic STRAP_LATCHED,
	output logic [NUM_CLK_OUT-1:0] CLK_RUN_EN,
	output logic CLK_OUT_OE,
	output logic PLL_BYPASS,
	output logic SPREAD_EN,
	output logic [4:0] FREQ_CODE,
	output logic FREQ_SLEWING
);

	localparam int unsigned CW = $clog2(SAMPLE_CYCLES + 1);

	// Elaboration check: the sampling interval needs at least two cycles
	if (SAMPLE_CYCLES < 2) begin : g_bad_sample
		$error("SAMPLE_CYCLES must be at least 2");
	end

	// Pin synchronisers: first stage read only by the second
	logic [4:0] pin_m_q;
	logic [4:0] pin_s_q;
	logic scl_p_q;
	logic sda_p_q;
	wire logic [4:0] pin_raw = {CPU_SPEED_SELECT_PIN, CRYSTAL_INPUT, REFERENCE_COPY_STRAP_PIN_I,
		SERIAL_DATA_PIN_I, SERIAL_CLOCK_PIN};
	wire logic scl_s = pin_s_q[0];
	wire logic sda_s = pin_s_q[1];
	wire logic strap_s = pin_s_q[2];
	wire logic xtal_s = pin_s_q[3];
	wire logic speed_s = pin_s_q[4];

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pin_m_q <= 5'h03; // Serial wires reset to their idle high, so no false edge follows reset
			pin_s_q <= 5'h03;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			pin_m_q <= pin_raw;
			pin_s_q <= pin_m_q;
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// Strap sequencer; ARST_N is the power-on detector, so nothing else can clear the latch
	ssfg_strap_t strap_st_q;
	ssfg_strap_t strap_st_d;
	logic [CW-1:0] sample_cnt_q;
	logic strap_val_q;
	logic ref_copy_q;
	wire logic sample_end = (sample_cnt_q == CW'(SAMPLE_CYCLES - 1));

	always_comb begin
		strap_st_d = strap_st_q;
		case (strap_st_q)
			STRAP_SAMPLE: if (sample_end) strap_st_d = STRAP_LATCH;
			STRAP_LATCH: strap_st_d = STRAP_DRIVE;
			STRAP_DRIVE: strap_st_d = STRAP_DRIVE;
			default: strap_st_d = STRAP_SAMPLE;
		endcase
	end

	// Timer runs from reset release; the latch is taken in the cycle the timer expires
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			strap_st_q <= STRAP_SAMPLE;
			sample_cnt_q <= '0;
			strap_val_q <= 1'b0;
		end else begin
			strap_st_q <= strap_st_d;
			if (strap_st_q == STRAP_SAMPLE) begin
				sample_cnt_q <= sample_cnt_q + CW'(1);
			end
			if (strap_st_q == STRAP_SAMPLE && sample_end) begin
				strap_val_q <= strap_s;
			end
		end
	end

	// Reference copy retimed from the crystal; coarse at this rate, but never glitches
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ref_copy_q <= 1'b0;
		end else begin
			ref_copy_q <= xtal_s;
		end
	end

	// Control registers and serial receiver state
	ssfg_cfg_t cfg_q;
	logic [7:0] shadow_q [0:2];
	ssfg_ser_t ser_st_q;
	logic [3:0] bit_cnt_q;
	logic [3:0] byte_idx_q;
	logic [7:0] shift_q;
	logic match_q;
	logic ack_drv_q;

	wire logic ser_start = scl_s && scl_p_q && sda_p_q && !sda_s;
	wire logic ser_stop = scl_s && scl_p_q && !sda_p_q && sda_s;
	wire logic scl_rise = scl_s && !scl_p_q;
	wire logic scl_fall = !scl_s && scl_p_q;
	wire logic byte_done = (ser_st_q == SER_RX) && scl_fall && (bit_cnt_q == SER_BITS_PER_BYTE);
	wire logic addr_ok = (shift_q == SER_SLAVE_ADDR);
	wire logic is_addr = (byte_idx_q == 4'h0);
	wire logic in_seq = (byte_idx_q < SER_SEQ_BYTES);
	wire logic cfg_pos = (byte_idx_q >= SER_FIRST_CFG_IDX) && (byte_idx_q <= SER_LAST_CFG_IDX);
	wire logic give_ack = is_addr ? addr_ok : (match_q && in_seq);
	wire logic last_byte = (byte_idx_q == SER_LAST_CFG_IDX);
	wire logic [1:0] shadow_idx = 2'(byte_idx_q - SER_FIRST_CFG_IDX);

	// Byte-level receiver: start always resynchronises, stop always aborts
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ser_st_q <= SER_IDLE;
			bit_cnt_q <= 4'h0;
			byte_idx_q <= 4'h0;
			shift_q <= 8'h00;
			match_q <= 1'b0;
			ack_drv_q <= 1'b0;
		end else if (ser_start) begin
			ser_st_q <= SER_RX;
			bit_cnt_q <= 4'h0;
			byte_idx_q <= 4'h0;
			match_q <= 1'b0;
			ack_drv_q <= 1'b0;
		end else if (ser_stop) begin
			ser_st_q <= SER_IDLE;
			ack_drv_q <= 1'b0;
		end else begin
			case (ser_st_q)
				SER_RX: begin
					if (scl_rise && bit_cnt_q < SER_BITS_PER_BYTE) begin
						shift_q <= {shift_q[6:0], sda_s};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
					if (byte_done) begin
						if (is_addr) begin
							match_q <= addr_ok;
						end
						ack_drv_q <= give_ack;
						ser_st_q <= give_ack ? SER_ACK : SER_SKIP;
					end
				end
				SER_ACK: begin
					if (scl_fall) begin
						ack_drv_q <= 1'b0;
						bit_cnt_q <= 4'h0;
						byte_idx_q <= byte_idx_q + 4'h1;
						ser_st_q <= SER_RX;
					end
				end
				SER_SKIP: ser_st_q <= SER_SKIP;
				SER_IDLE: ser_st_q <= SER_IDLE;
				default: ser_st_q <= SER_IDLE;
			endcase
		end
	end

	// Data bytes three to five wait in a shadow; all four land together on the last byte
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cfg_q <= CFG_DEFAULT;
			shadow_q[0] <= 8'h00;
			shadow_q[1] <= 8'h00;
			shadow_q[2] <= 8'h00;
		end else if (byte_done && match_q && cfg_pos) begin
			if (last_byte) begin
				cfg_q <= '{b3: shadow_q[0], b4: shadow_q[1], b5: shadow_q[2], b6: shift_q};
			end else begin
				shadow_q[shadow_idx] <= shift_q;
			end
		end
	end

	// Open-drain data pin: only ever pulled low for acknowledge, never carries register data
	assign SERIAL_DATA_PIN_O = 1'b0;
	assign SERIAL_DATA_PIN_OE = ack_drv_q;

	// Mode and frequency decode
	wire ssfg_mode_t mode = ssfg_mode_t'(cfg_q.b3[B3_MODE_MSB:B3_MODE_LSB]);
	wire logic table_sel = cfg_q.b3[B3_TABLE_SEL];
	wire logic [4:0] freq_target = table_sel ? {1'b1, cfg_q.b3[B3_SEL_MSB:B3_SEL_LSB]} : {4'h0, speed_s};

	// Frequency slew: one code step per tick so the synthesizer never jumps
	logic [15:0] ramp_div_q;
	logic [15:0] ramp_cnt_q;
	logic [4:0] freq_cur_q;
	wire logic ramp_tick = (ramp_cnt_q >= ramp_div_q);
	wire logic slewing = (freq_cur_q != freq_target);

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ramp_cnt_q <= 16'h0000;
			freq_cur_q <= 5'h00;
		end else begin
			ramp_cnt_q <= ramp_tick ? 16'h0000 : ramp_cnt_q + 16'h0001;
			if (ramp_tick && slewing) begin
				freq_cur_q <= (freq_cur_q < freq_target) ? freq_cur_q + 5'h01 : freq_cur_q - 5'h01;
			end
		end
	end

	// Per-output enables from bytes four and five
	wire logic [NUM_CLK_OUT-1:0] out_en = {cfg_q.b5[B5_PCIF_EN], cfg_q.b5[B5_PCI6_EN], cfg_q.b5[B5_PCI5_EN],
		cfg_q.b5[B5_PCI4_EN], cfg_q.b5[B5_PCI3_EN], cfg_q.b5[B5_PCI2_EN], cfg_q.b5[B5_PCI1_EN],
		cfg_q.b4[B4_ALT_EN], cfg_q.b4[B4_CPU1_EN], cfg_q.b4[B4_CPU0_EN]};
	wire logic driving = (strap_st_q == STRAP_DRIVE);

	// Output stage registers; run, clock and strap pin enables are held off until the strap sequence completes, bypass and spread follow the mode at once
	logic [NUM_CLK_OUT-1:0] run_en_q;
	logic clk_oe_q;
	logic bypass_q;
	logic spread_q;
	logic strap_oe_q;
	logic strap_o_q;

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			run_en_q <= '0;
			clk_oe_q <= 1'b0;
			bypass_q <= 1'b0;
			spread_q <= 1'b0;
			strap_oe_q <= 1'b0;
			strap_o_q <= 1'b0;
		end else begin
			run_en_q <= driving ? out_en : '0;
			clk_oe_q <= driving && (mode != MODE_TRISTATE);
			bypass_q <= (mode == MODE_TEST);
			spread_q <= (mode == MODE_SPREAD);
			strap_oe_q <= driving && (mode != MODE_TRISTATE);
			strap_o_q <= ref_copy_q;
		end
	end

	assign CLK_RUN_EN = run_en_q;
	assign CLK_OUT_OE = clk_oe_q;
	assign PLL_BYPASS = bypass_q;
	assign SPREAD_EN = spread_q;
	assign REFERENCE_COPY_STRAP_PIN_OE = strap_oe_q;
	assign REFERENCE_COPY_STRAP_PIN_O = strap_o_q;
	assign HALF_RATE_SELECT_STRAP = strap_val_q;
	assign STRAP_LATCHED = driving;
	assign FREQ_CODE = freq_cur_q;
	assign FREQ_SLEWING = slewing;

	// APB decode: zero wait states, read data captured in the setup cycle
	wire logic apb_setup = PSEL && !PENABLE;
	wire logic apb_access = PSEL && PENABLE;
	wire logic hit_status = (PADDR == REG_STATUS);
	wire logic hit_config = (PADDR == REG_CONFIG);
	wire logic hit_ramp = (PADDR == REG_RAMP_DIV);
	wire logic hit_freq = (PADDR == REG_FREQ);
	wire logic hit_any = hit_status || hit_config || hit_ramp || hit_freq;
	wire logic [31:0] status_word = {28'h000_0000, slewing, (ser_st_q != SER_IDLE), strap_val_q, driving};
	wire logic [31:0] rd_mux = hit_status ? status_word :
		hit_config ? cfg_q :
		hit_ramp ? {16'h0000, ramp_div_q} :
		hit_freq ? {19'h0_0000, 3'h0, freq_target, 5'h00} | {27'h000_0000, freq_cur_q} : 32'h0000_0000;

	logic [31:0] prdata_q;

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			prdata_q <= 32'h0000_0000;
			ramp_div_q <= RAMP_DIV_RESET;
		end else begin
			if (apb_setup && !PWRITE) begin
				prdata_q <= rd_mux;
			end
			if (apb_access && PWRITE && hit_ramp) begin
				ramp_div_q <= PWDATA[15:0];
			end
		end
	end

	assign PRDATA = prdata_q;
	assign PREADY = 1'b1;
	assign PSLVERR = apb_access && !hit_any;

endmodule : ssfg_top

/* ssfg_top_tb.sv */
// Self-checking bench for the strap latch and serial configuration block
`timescale 1ns/10ps
module ssfg_top_tb;
	import ssfg_pkg::*;
	logic clk = 0, arst_n = 0, psel = 0, pen = 0, pwr = 0, xtal = 0, spd = 0, strap = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, exp_cfg, rd;
	logic pready, pslverr, scl, sda_low, sda_oe, ref_o, ref_oe, half, clk_oe, bypass, spread, err;
	logic [9:0] run_en;
	logic [4:0] fcode, ftgt;
	logic slew, latched;
	logic [7:0] mk [10] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFB, 8'h45, 8'hEF, 8'h00};
	wire sda = !(sda_low || sda_oe);
	wire ref_pin = ref_oe ? ref_o : strap;
	int n_mismatch = 0, checks_done = 0, seed = 32'h4b78, xc = 0;
	ssfg_top #(.SAMPLE_CYCLES(50)) dut_u (.SYS_CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.SERIAL_CLOCK_PIN(scl), .SERIAL_DATA_PIN_I(sda), .SERIAL_DATA_PIN_O(), .SERIAL_DATA_PIN_OE(sda_oe),
		.REFERENCE_COPY_STRAP_PIN_I(ref_pin), .REFERENCE_COPY_STRAP_PIN_O(ref_o),
		.REFERENCE_COPY_STRAP_PIN_OE(ref_oe), .CRYSTAL_INPUT(xtal), .CPU_SPEED_SELECT_PIN(spd),
		.HALF_RATE_SELECT_STRAP(half), .STRAP_LATCHED(latched), .CLK_RUN_EN(run_en), .CLK_OUT_OE(clk_oe),
		.PLL_BYPASS(bypass), .SPREAD_EN(spread), .FREQ_CODE(fcode), .FREQ_SLEWING(slew));
	ssfg_host host_u (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
	initial forever #2 clk = ~clk;
	// Coarse reference near 14 MHz, 18 system cycles a period
	always @(posedge clk) begin
		xc <= (xc == 8) ? 0 : xc + 1;
		if (xc == 8) xtal <= ~xtal;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic chkb(input logic g, input logic e);
		chk({31'h0, g}, {31'h0, e});
	endtask : chkb
	// Master holds the request until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		pen <= 0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		pen <= 0;
		// Let an edge pass so a following call never reassigns psel in this time step
		@(posedge clk);
	endtask : apb
	// Output controls follow the model's copy of the control bytes
	task automatic outs;
		logic [1:0] md;
		md = exp_cfg[25:24];
		apb(0, REG_CONFIG, 0);
		chk(rd, exp_cfg);
		chk({22'h0, run_en}, {22'h0, exp_cfg[15:13], exp_cfg[11:8], exp_cfg[22], exp_cfg[18], exp_cfg[16]});
		chkb(bypass, md == MODE_TEST);
		chkb(spread, md == MODE_SPREAD);
		chkb(clk_oe, md != MODE_TRISTATE);
		chkb(ref_oe, md != MODE_TRISTATE);
		chkb(half, strap);
		// Target code: table select picks the byte-three code, otherwise the speed pin
		ftgt = exp_cfg[27] ? {1'b1, exp_cfg[31:28]} : {4'h0, spd};
		apb(0, REG_FREQ, 0);
		chk({27'h0, rd[9:5]}, {27'h0, ftgt});
	endtask : outs
	// Sends nb bytes; reserved bits are written as zero
	task automatic xfer(input int nb, input logic [7:0] ad, input logic [1:0] md);
		logic [7:0] q[$];
		logic a;
		q.push_back(ad);
		for (int i = 1; i < nb; i++) q.push_back(8'($random(seed)) & mk[i % 10]);
		q[6][1:0] = md;
		host_u.start();
		foreach (q[i]) begin
			host_u.put_byte(q[i], a);
			chkb(a, q[0] == SER_SLAVE_ADDR && i < 10);
		end
		host_u.stop();
		if (q[0] == SER_SLAVE_ADDR && nb > 9) exp_cfg = {q[6], q[7], q[8], q[9]};
		outs();
		// At most 31 steps of 8 cycles each with the ramp divider at 7
		repeat (300) @(posedge clk);
		chk({26'h0, slew, fcode}, {26'h0, 1'b0, ftgt});
		$display("test transfer of %0d bytes done", nb);
	endtask : xfer
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test
	initial begin
		#300_000;
		n_mismatch++;
		end_of_test();
	end
	// Two power-ups with opposite straps; the second lands mid-run
	initial begin
		for (int p = 0; p < 2; p++) begin
			arst_n <= 0;
			strap <= p[0];
			spd <= 1'($random(seed));
			exp_cfg = CFG_DEFAULT;
			repeat (12) @(posedge clk);
			arst_n <= 1;
			repeat (40) @(posedge clk);
			chk({30'h0, latched, ref_oe}, 32'h0);
			repeat (20) @(posedge clk);
			chkb(latched, 1'b1);
			apb(0, REG_STATUS, 0);
			chk(rd & 32'h3, {30'h0, strap, 1'b1});
			outs();
			apb(0, REG_RAMP_DIV, 0);
			chk(rd, {16'h0, RAMP_DIV_RESET});
			apb(1, REG_RAMP_DIV, 32'h0000_0007);
			apb(0, REG_RAMP_DIV, 0);
			chk(rd, 32'h0000_0007);
			apb(0, 8'h10, 0);
			chk({31'h0, err}, 32'h0000_0001);
			$display("test power-up pass %0d done", p);
			for (int m = 0; m < 4; m++) xfer(10, SER_SLAVE_ADDR, m[1:0]);
			xfer(10, SER_SLAVE_ADDR ^ 8'(1 << ($random(seed) & 7)), 2'b00);
			xfer(7, SER_SLAVE_ADDR, 2'b00);
			xfer(11, SER_SLAVE_ADDR, 2'b00);
		end
		end_of_test();
	end
endmodule : ssfg_top_tb
